// file: src/fcs_flash_sequencer.v
// Flash command sequencer between the CPU bus and the flash array macro.
//
// Overview of operation
// - Invert toggle bit per read while busy.
// - First status read after start returns one.
// - Block array reads and fetches while busy.
// - Byte reads in one transfer, byte programming.
// - Erase whole array or one 4-kbyte sector.
// - Sequences accepted only after enable code 0011.
// - Code 1100 blocks further sequences.
// - Six-write chip erase sequence ending 10.
// - Four-write byte program sequence.
// - Boot loader already stopped the watchdog.
// - Sector erase ends 30 at sector address.
// - Byte program finishes within 40 microseconds.
`timescale 1ns/1ns
`default_nettype none
`include "fcs_defines.vh"

module fcs_flash_sequencer
#(
  parameter [18:0] ERASE_CYCLES = `FCS_ERASE_CYCLES
)
(
  // Clock and reset.
  input wire clk,
  input wire nrst,
  // CPU bus toward the flash area.
  input wire bus_rd,
  input wire bus_wr,
  input wire [15:0] bus_addr,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  output reg bus_rvalid,
  output reg busy,
  // Command-sequence enable field of the flash control register.
  input wire [3:0] command_sequence_enable_field,
  // Flash array macro.
  input wire [7:0] macro_rdata,
  output reg [15:0] macro_addr,
  output reg [7:0] macro_wdata,
  output reg macro_rd,
  output reg macro_prog,
  output reg macro_chip_erase,
  output reg macro_sector_erase,
  output reg macro_sec_prog,
  output reg [3:0] macro_sector
);

  // ********************************************************
  // Constants and states.
  // ********************************************************
  localparam [18:0] PROG_CYCLES = `FCS_PROG_CYCLES;
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_UNL1 = 9'h002;
  localparam [8:0] S_UNL2 = 9'h004;
  localparam [8:0] S_ERS3 = 9'h008;
  localparam [8:0] S_ERS4 = 9'h010;
  localparam [8:0] S_ERS5 = 9'h020;
  localparam [8:0] S_PGM = 9'h040;
  localparam [8:0] S_SEC = 9'h080;
  localparam [8:0] S_BUSY = 9'h100;

  // Checks one bus write against an expected address and data.
  function wr_match;
    input [15:0] addr;
    input [7:0] data;
    input [15:0] exp_addr;
    input [7:0] exp_data;
    begin
      wr_match = (addr == exp_addr) && (data == exp_data);
    end
  endfunction

  // ********************************************************
  // Reset release.
  // ********************************************************
  reg rst_sync1;
  reg rst_n;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  // ********************************************************
  // Sequence state machine.
  // ********************************************************
  reg [8:0] state;
  reg [8:0] next_state;
  reg cmd_en;
  reg start;
  reg [1:0] next_op;
  reg [18:0] timer;
  reg toggle;
  reg rd_pend;
  reg rd_status;
  wire wr_ok;

  assign wr_ok = bus_wr && cmd_en;

  always @*
  begin
    next_state = state;
    start = 1'b0;
    next_op = `FCS_OP_PROGRAM;
    case (state)
      S_IDLE:
        if (wr_ok)
        begin
          if (wr_match(bus_addr, bus_wdata, `FCS_UNLOCK_ADDR1,
                       `FCS_DATA_UNLOCK1))
            next_state = S_UNL1;
        end
      S_UNL1:
        if (wr_ok)
        begin
          if (wr_match(bus_addr, bus_wdata, `FCS_UNLOCK_ADDR2,
                       `FCS_DATA_UNLOCK2))
            next_state = S_UNL2;
          else
            next_state = S_IDLE;
        end
      S_UNL2:
        if (wr_ok)
        begin
          if (wr_match(bus_addr, bus_wdata, `FCS_UNLOCK_ADDR1,
                       `FCS_CMD_PROGRAM))
            next_state = S_PGM;
          else if (wr_match(bus_addr, bus_wdata, `FCS_UNLOCK_ADDR1,
                            `FCS_CMD_ERASE))
            next_state = S_ERS3;
          else if (wr_match(bus_addr, bus_wdata, `FCS_UNLOCK_ADDR1,
                            `FCS_CMD_SEC_PROG))
            next_state = S_SEC;
          else
            next_state = S_IDLE;
        end
      S_ERS3:
        if (wr_ok)
        begin
          if (wr_match(bus_addr, bus_wdata, `FCS_UNLOCK_ADDR1,
                       `FCS_DATA_UNLOCK1))
            next_state = S_ERS4;
          else
            next_state = S_IDLE;
        end
      S_ERS4:
        if (wr_ok)
        begin
          if (wr_match(bus_addr, bus_wdata, `FCS_UNLOCK_ADDR2,
                       `FCS_DATA_UNLOCK2))
            next_state = S_ERS5;
          else
            next_state = S_IDLE;
        end
      S_ERS5:
        if (wr_ok)
        begin
          if (wr_match(bus_addr, bus_wdata, `FCS_UNLOCK_ADDR1,
                       `FCS_CMD_CHIP_ERASE))
          begin
            next_state = S_BUSY;
            start = 1'b1;
            next_op = `FCS_OP_CHIP;
          end
          else if (bus_wdata == `FCS_CMD_SECTOR_ERASE)
          begin
            next_state = S_BUSY;
            start = 1'b1;
            next_op = `FCS_OP_SECTOR;
          end
          else
            next_state = S_IDLE;
        end
      S_PGM:
        if (wr_ok)
        begin
          next_state = S_BUSY;
          start = 1'b1;
          next_op = `FCS_OP_PROGRAM;
        end
      S_SEC:
        if (wr_ok)
        begin
          if (wr_match(bus_addr, bus_wdata, `FCS_SEC_PROG_ADDR,
                       `FCS_DATA_SEC_PROG))
          begin
            next_state = S_BUSY;
            start = 1'b1;
            next_op = `FCS_OP_SECURITY;
          end
          else
            next_state = S_IDLE;
        end
      S_BUSY:
        if (timer == 19'h00000)
          next_state = S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
    if (!cmd_en && (state != S_BUSY))
      next_state = S_IDLE;
  end

  // ********************************************************
  // Enable latch, operation timer and macro strobes.
  // ********************************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      cmd_en <= 1'b0;
      timer <= 19'h00000;
      busy <= 1'b0;
      macro_prog <= 1'b0;
      macro_chip_erase <= 1'b0;
      macro_sector_erase <= 1'b0;
      macro_sec_prog <= 1'b0;
      macro_sector <= 4'h0;
      macro_wdata <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (command_sequence_enable_field == `FCS_SEQ_ENABLE)
        cmd_en <= 1'b1;
      else if (command_sequence_enable_field == `FCS_SEQ_DISABLE)
        cmd_en <= 1'b0;
      macro_prog <= start && (next_op == `FCS_OP_PROGRAM);
      macro_chip_erase <= start && (next_op == `FCS_OP_CHIP);
      macro_sector_erase <= start && (next_op == `FCS_OP_SECTOR);
      macro_sec_prog <= start && (next_op == `FCS_OP_SECURITY);
      busy <= (next_state == S_BUSY);
      if (start)
      begin
        macro_wdata <= bus_wdata;
        macro_sector <= bus_addr[`FCS_SECTOR_MSB:`FCS_SECTOR_LSB];
        if ((next_op == `FCS_OP_PROGRAM) || (next_op == `FCS_OP_SECURITY))
          timer <= PROG_CYCLES - 19'h00001;
        else
          timer <= ERASE_CYCLES - 19'h00001;
      end
      else if (timer != 19'h00000)
        timer <= timer - 19'h00001;
    end
  end

  // ********************************************************
  // Read path and toggle status.
  // ********************************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      macro_addr <= 16'h0000;
      macro_rd <= 1'b0;
      rd_pend <= 1'b0;
      rd_status <= 1'b0;
      toggle <= 1'b1;
      bus_rdata <= 8'h00;
      bus_rvalid <= 1'b0;
    end
    else
    begin
      rd_pend <= bus_rd;
      rd_status <= bus_rd && (state == S_BUSY);
      macro_rd <= bus_rd && (state != S_BUSY);
      if (start)
        macro_addr <= bus_addr;
      else if (bus_rd && (state != S_BUSY))
        macro_addr <= bus_addr;
      if (start)
        toggle <= 1'b1;
      else if (bus_rd && (state == S_BUSY))
        toggle <= ~toggle;
      bus_rvalid <= rd_pend;
      if (rd_pend)
      begin
        if (rd_status)
        begin
          bus_rdata <= 8'h00;
          bus_rdata[`FCS_TOGGLE_BIT] <= ~toggle;
        end
        else
          bus_rdata <= macro_rdata;
      end
    end
  end

endmodule

`default_nettype wire

// file: src/fcs_defines.vh
// Constants for the flash command sequencer.
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

`define FCS_CLK_MHZ 10
`define FCS_UNLOCK_ADDR1 16'h4555
`define FCS_UNLOCK_ADDR2 16'h4aaa
`define FCS_SEC_PROG_ADDR 16'h4f7f
`define FCS_DATA_UNLOCK1 8'haa
`define FCS_DATA_UNLOCK2 8'h55
`define FCS_CMD_PROGRAM 8'ha0
`define FCS_CMD_ERASE 8'h80
`define FCS_CMD_SEC_PROG 8'ha5
`define FCS_CMD_CHIP_ERASE 8'h10
`define FCS_CMD_SECTOR_ERASE 8'h30
`define FCS_DATA_SEC_PROG 8'h00
`define FCS_SEQ_ENABLE 4'h3
`define FCS_SEQ_DISABLE 4'hc
`define FCS_TOGGLE_BIT 6
`define FCS_SECTOR_MSB 15
`define FCS_SECTOR_LSB 12
`define FCS_PROG_TIME_US 40
`define FCS_PROG_CYCLES (`FCS_PROG_TIME_US * `FCS_CLK_MHZ)
`define FCS_ERASE_TIME_MS 30
`define FCS_ERASE_CYCLES (`FCS_ERASE_TIME_MS * 1000 * `FCS_CLK_MHZ)
`define FCS_OP_PROGRAM 2'h0
`define FCS_OP_CHIP 2'h1
`define FCS_OP_SECTOR 2'h2
`define FCS_OP_SECURITY 2'h3

`endif

// file: verif/fcs_flash_model.sv
// Behavioural flash array macro facing the sequencer.
`timescale 1ns/1ns
`default_nettype none
module fcs_flash_model
(
  // Clock.
  input wire logic clk,
  // Array control.
  input wire logic [15:0] macro_addr,
  input wire logic [7:0] macro_wdata,
  input wire logic macro_rd,
  input wire logic macro_prog,
  input wire logic macro_chip_erase,
  input wire logic macro_sector_erase,
  input wire logic macro_sec_prog,
  input wire logic [3:0] macro_sector,
  // Array data.
  output logic [7:0] macro_rdata
);
  logic [7:0] mem [0:65535];
  int i;
  // Unstrobed reads show inverted data, never a held value.
  assign macro_rdata = macro_rd ? mem[macro_addr] : ~mem[macro_addr];
  initial for (i = 0; i < 65536; i++) mem[i] = 8'hff;
  always @(posedge clk)
  begin
    if (macro_prog) mem[macro_addr] <= mem[macro_addr] & macro_wdata;
    if (macro_chip_erase) for (i = 0; i < 65536; i++) mem[i] <= 8'hff;
    if (macro_sector_erase)
      for (i = 0; i < 4096; i++) mem[{macro_sector, i[11:0]}] <= 8'hff;
  end
endmodule
`default_nettype wire

// file: verif/fcs_checker_asserts.sv
// Port assertions for the flash command sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "fcs_defines.vh"
module fcs_checker
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // CPU bus.
  input wire logic bus_rd,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire logic busy,
  input wire logic [3:0] command_sequence_enable_field,
  // Flash array macro.
  input wire logic [15:0] macro_addr,
  input wire logic macro_rd,
  input wire logic macro_prog,
  input wire logic macro_chip_erase,
  input wire logic macro_sector_erase,
  input wire logic macro_sec_prog,
  input wire logic [3:0] macro_sector
);
  wire st = macro_prog | macro_chip_erase | macro_sector_erase | macro_sec_prog;
  reg [1:0] rb;
  reg exp6;
  reg en;
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      rb <= 2'h0;
      exp6 <= 1'b1;
      en <= 1'b0;
    end
    else
    begin
      rb <= {rb[0], bus_rd & busy};
      if (st) exp6 <= 1'b1;
      else if (bus_rvalid & rb[1]) exp6 <= ~exp6;
      if (command_sequence_enable_field == `FCS_SEQ_ENABLE) en <= 1'b1;
      else if (command_sequence_enable_field == `FCS_SEQ_DISABLE) en <= 1'b0;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_RD_ANSWER: assert property (bus_rd |-> ##2 bus_rvalid)
    else $error("read answer missing");
  AST_RD_ARRAY: assert property (bus_rd && !busy |=> macro_rd
    && macro_addr == $past(bus_addr)) else $error("array read wrong");
  AST_NO_ARRAY: assert property (busy |-> !macro_rd)
    else $error("array read while busy");
  AST_STATUS: assert property (bus_rvalid && rb[1] |->
    bus_rdata == {1'b0, exp6, 6'h00}) else $error("status byte wrong");
  AST_START_BUSY: assert property (st |-> $rose(busy))
    else $error("start without busy");
  AST_PROG_TIME: assert property (macro_prog || macro_sec_prog |->
    ##[1:400] !busy) else $error("program too long");
  AST_ENABLED: assert property (st |-> $past(en))
    else $error("start while disabled");
  AST_SECTOR: assert property (macro_sector_erase |->
    macro_sector == $past(bus_addr[15:12])) else $error("sector wrong");
  C_PROG: cover property (macro_prog);
  C_SECT: cover property (macro_sector_erase);
  C_CHIP: cover property (macro_chip_erase);
  C_SECP: cover property (macro_sec_prog);
endmodule
bind fcs_flash_sequencer fcs_checker chk (
  .clk(clk),
  .nrst(nrst),
  .bus_rd(bus_rd),
  .bus_addr(bus_addr),
  .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata),
  .bus_rvalid(bus_rvalid),
  .busy(busy),
  .command_sequence_enable_field(command_sequence_enable_field),
  .macro_addr(macro_addr),
  .macro_rd(macro_rd),
  .macro_prog(macro_prog),
  .macro_chip_erase(macro_chip_erase),
  .macro_sector_erase(macro_sector_erase),
  .macro_sec_prog(macro_sec_prog),
  .macro_sector(macro_sector)
);
`default_nettype wire

// file: verif/fcs_tb.sv
// Self-checking bench for the flash command sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "fcs_defines.vh"
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic bus_rd = 1'b0;
  logic bus_wr = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00;
  logic [3:0] command_sequence_enable_field = 4'h0;
  logic [7:0] bus_rdata, macro_rdata, macro_wdata, v;
  logic [15:0] macro_addr;
  logic [3:0] macro_sector;
  logic bus_rvalid, busy, macro_rd, macro_prog, macro_chip_erase;
  logic macro_sector_erase, macro_sec_prog;
  logic [15:0] pa [4];
  logic [7:0] pd [4];
  int fails = 0;
  int check_count = 0;
  int n;
  fcs_flash_sequencer #(.ERASE_CYCLES(19'd50)) dut (
    .clk(clk),
    .nrst(nrst),
    .bus_rd(bus_rd),
    .bus_wr(bus_wr),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid),
    .busy(busy),
    .command_sequence_enable_field(command_sequence_enable_field),
    .macro_rdata(macro_rdata),
    .macro_addr(macro_addr),
    .macro_wdata(macro_wdata),
    .macro_rd(macro_rd),
    .macro_prog(macro_prog),
    .macro_chip_erase(macro_chip_erase),
    .macro_sector_erase(macro_sector_erase),
    .macro_sec_prog(macro_sec_prog),
    .macro_sector(macro_sector)
  );
  fcs_flash_model model (
    .clk(clk),
    .macro_addr(macro_addr),
    .macro_wdata(macro_wdata),
    .macro_rd(macro_rd),
    .macro_prog(macro_prog),
    .macro_chip_erase(macro_chip_erase),
    .macro_sector_erase(macro_sector_erase),
    .macro_sec_prog(macro_sec_prog),
    .macro_sector(macro_sector),
    .macro_rdata(macro_rdata)
  );
  initial forever #50 clk = ~clk;
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [15:0] a);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rvalid", {7'h0, bus_rvalid}, 8'h01);
    v = bus_rdata;
  endtask
  task seq(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d,
    input logic b);
    wr(`FCS_UNLOCK_ADDR1, `FCS_DATA_UNLOCK1);
    wr(`FCS_UNLOCK_ADDR2, `FCS_DATA_UNLOCK2);
    wr(`FCS_UNLOCK_ADDR1, c);
    if (c == `FCS_CMD_ERASE)
    begin
      wr(`FCS_UNLOCK_ADDR1, `FCS_DATA_UNLOCK1);
      wr(`FCS_UNLOCK_ADDR2, `FCS_DATA_UNLOCK2);
    end
    wr(a, d);
    chk("busy", {7'h0, busy}, {7'h0, b});
  endtask
  task poll(input logic [15:0] a);
    logic [7:0] p;
    rd(a);
    chk("first status", v, 8'h40);
    n = 0;
    do
    begin
      p = v;
      rd(a);
      n++;
    end
    while (v !== p && n < 300);
    chk("poll count", {7'h0, n <= `FCS_PROG_CYCLES / 3 + 2}, 8'h01);
  endtask
  task rej(input logic [15:0] a);
    seq(`FCS_CMD_PROGRAM, a, 8'h00, 1'b0);
    rd(a);
    chk("refused", v, 8'hff);
  endtask
  function logic [7:0] ev(input int k);
    return pa[k][15:12] == 4'h8 ? 8'hff : pd[k];
  endfunction
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #2000000;
    fails++;
    wrap_up;
  end
  initial
  begin
    // The bench acts as control code run from RAM with interrupts masked.
    void'($urandom(37));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rej(16'h2000);
    $display("test disabled done");
    command_sequence_enable_field <= `FCS_SEQ_ENABLE;
    @(posedge clk);
    seq(`FCS_CMD_ERASE, `FCS_UNLOCK_ADDR1, `FCS_CMD_CHIP_ERASE, 1'b1);
    poll(`FCS_UNLOCK_ADDR1);
    rd(16'($urandom));
    chk("erased", v, 8'hff);
    for (int k = 0; k < 4; k++)
    begin
      pa[k] = {4'h8 + 4'(k), 12'($urandom)};
      pd[k] = 8'($urandom);
      seq(`FCS_CMD_PROGRAM, pa[k], pd[k], 1'b1);
      poll(pa[k]);
      rd(pa[k]);
      chk("programmed", v, pd[k]);
    end
    $display("test program done");
    wr(`FCS_UNLOCK_ADDR1, `FCS_DATA_UNLOCK1);
    wr(`FCS_UNLOCK_ADDR1, `FCS_DATA_UNLOCK2);
    wr(`FCS_UNLOCK_ADDR1, `FCS_CMD_PROGRAM);
    wr(16'h1234, 8'h00);
    chk("busy", {7'h0, busy}, 8'h00);
    rd(16'h1234);
    chk("abandoned", v, 8'hff);
    seq(`FCS_CMD_ERASE, {4'h8, 12'($urandom)}, `FCS_CMD_SECTOR_ERASE, 1'b1);
    poll(pa[0]);
    for (int k = 0; k < 4; k++)
    begin
      rd(pa[k]);
      chk("sector", v, ev(k));
    end
    seq(`FCS_CMD_SEC_PROG, `FCS_SEC_PROG_ADDR, `FCS_DATA_SEC_PROG, 1'b1);
    poll(`FCS_SEC_PROG_ADDR);
    seq(`FCS_CMD_ERASE, `FCS_UNLOCK_ADDR1, `FCS_CMD_CHIP_ERASE, 1'b1);
    poll(`FCS_UNLOCK_ADDR1);
    for (int k = 1; k < 4; k++)
    begin
      rd(pa[k]);
      chk("chip erased", v, 8'hff);
    end
    $display("test erase done");
    command_sequence_enable_field <= `FCS_SEQ_DISABLE;
    @(posedge clk);
    rej(16'h3000);
    $display("test disable done");
    wrap_up;
  end
endmodule
`default_nettype wire
